/* spc_defs.vh */
// Constants for the serial port configuration and fault indicator block
`ifndef SPC_DEFS_VH
`define SPC_DEFS_VH
// Register byte offsets
`define SPC_OFF_FAULT   12'h000
`define SPC_OFF_SWCFG   12'h004
`define SPC_OFF_SWADDR  12'h008
`define SPC_OFF_STATUS  12'h00C
`define SPC_OFF_ACTIVE  12'h010
// Software framing fields
`define SPC_CFG_BAUD_LSB   0
`define SPC_CFG_PAR_EN     4
`define SPC_CFG_PAR_ODD    5
`define SPC_CFG_DATA8      6
`define SPC_CFG_STOP2      7
`define SPC_CFG_RST        8'h00
`define SPC_ADDR_RST       8'h01
// Baud codes, 0 = 19200 down to 15 = 50
`define SPC_BAUD_19200     4'h0
`define SPC_BAUD_9600      4'h1
`define SPC_BAUD_2400      4'h5
// Front switch positions
`define SPC_POS_TOP        2'h0
`define SPC_POS_MID        2'h1
`define SPC_POS_BOT        2'h2
// Address limits
`define SPC_ADDR_MAX_ROT   7'h40
`define SPC_ADDR_MAX_SW    8'hF7
// Fault codes
`define SPC_FC_KERNEL      16'h0000
`define SPC_FC_NONE        16'hFFFF
// Blink timing in ms and derived cycles at 250 MHz
`define SPC_CLK_KHZ        250000
`define SPC_BLINK_ON_MS    250
`define SPC_BLINK_OFF_MS   250
`define SPC_GAP_MS         1500
`define SPC_DEB_MS         10
`define SPC_ON_CYC   (`SPC_BLINK_ON_MS * `SPC_CLK_KHZ)
`define SPC_OFF_CYC  (`SPC_BLINK_OFF_MS * `SPC_CLK_KHZ)
`define SPC_GAP_CYC  (`SPC_GAP_MS * `SPC_CLK_KHZ)
`define SPC_DEB_CYC  (`SPC_DEB_MS * `SPC_CLK_KHZ)
`endif

/* spc_top.v */
// Serial port framing selection and run indicator fault blinker
// Notes on behaviour
// (RULE1) Fatal faults blink run indicator by group; code 0000 blinks continuously.
// (RULE2) Fault codes held as hex; each group covers a fixed code set.
// (RULE3) Codes 80B, 80C, 82E give two blinks.
// (RULE4) Codes 769 and 72A to 730 give three blinks.
// (RULE5) Codes 604 to 631 give four blinks.
// (RULE6) Codes 503, 52D give five blinks; 402 gives six.
// (RULE7) Codes 300, 301 give seven; 8001 to 8003 give eight.
// (RULE8) Write protect only with left switch at top.
// (RULE9) Right switch top: ASCII 2400, even, 7 data, 1 stop, fixed.
// (RULE10) Right switch middle: RTU 9600, even, 8 data, 1 stop, fixed.
// (RULE11) Fixed modes take address from rear rotary switches.
// (RULE12) Bottom: software framing, baud 19200 to 50, parity, 7/8, 1/2 stop.
// (RULE13) Software address accepted only from 1 to 247.
// (RULE14) RTU or ASCII selection defaults to bridge operation.
// (RULE15) Rotary value sets network node and serial address.
// (RULE16) Address is ten times tens digit plus ones digit.
// (RULE17) Rotary addresses above 64 not accepted.
// (RULE18) Address 0 or above 64 lights network indicator steadily.
// (RULE19) Blinks countable, groups split by longer dark gap.
// (RULE20) Switches debounced; new settings applied only between frames; node address, write protect and network indicator still update during a frame.
//
// The implementer's own choices: the APB slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "spc_defs.vh"
module spc_top #(
  parameter integer ON_CYC  = `SPC_ON_CYC,
  parameter integer OFF_CYC = `SPC_OFF_CYC,
  parameter integer GAP_CYC = `SPC_GAP_CYC,
  parameter integer DEB_CYC = `SPC_DEB_CYC
) (
  // Clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output wire        pslverr,
  output reg  [31:0] prdata,
  // Panel switches
  input  wire [1:0]  protect_switch,
  input  wire [1:0]  framing_switch,
  input  wire [3:0]  tens_address_selector,
  input  wire [3:0]  ones_address_selector,
  // Serial engine handshake
  input  wire        frame_busy,
  // Outputs to port, network and indicators
  output reg  [3:0]  port_baud_code,
  output reg         port_parity_en,
  output reg         port_parity_odd,
  output reg         port_data8,
  output reg         port_stop2,
  output reg         port_rtu,
  output reg  [7:0]  port_address,
  output reg  [6:0]  node_address,
  output reg         bridge_mode,
  output reg         write_protect,
  output reg         net_led_invalid,
  output reg         run_led_blink
);

  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_ON   = 2'h1;
  localparam [1:0] ST_OFF  = 2'h2;
  localparam [1:0] ST_GAP  = 2'h3;

  // Blink count for a fault code; zero for kernel code 0000 and for codes outside every group
  function [3:0] spc_group;
    input [15:0] code;
    begin
      spc_group = 4'h0;
      // (RULE3) two blink codes
      if (code == 16'h080B || code == 16'h080C || code == 16'h082E)
        spc_group = 4'h2;
      // (RULE4) three blink codes
      else if (code == 16'h0769 || (code >= 16'h072A && code <= 16'h0730))
        spc_group = 4'h3;
      // (RULE5) four blink codes
      else if (code >= 16'h0604 && code <= 16'h0631)
        spc_group = 4'h4;
      // (RULE6) five and six blink codes
      else if (code == 16'h0503 || code == 16'h052D)
        spc_group = 4'h5;
      else if (code == 16'h0402)
        spc_group = 4'h6;
      // (RULE7) seven and eight blink codes
      else if (code == 16'h0300 || code == 16'h0301)
        spc_group = 4'h7;
      else if (code >= 16'h8001 && code <= 16'h8003)
        spc_group = 4'h8;
    end
  endfunction

  // Two decimal digits to a binary value, ten times high plus low
  function [7:0] spc_bcd_value;
    input [3:0] hi;
    input [3:0] lo;
    begin
      spc_bcd_value = {1'b0, hi, 3'b000} + {3'b000, hi, 1'b0} + {4'h0, lo};
    end
  endfunction

  // A rotary position is a decimal digit only up to nine
  function spc_digit_ok;
    input [3:0] digit;
    begin
      spc_digit_ok = (digit <= 4'h9);
    end
  endfunction

  // APB write and read strobes
  wire wr_en = psel & penable & pwrite;
  wire rd_en = psel & penable & ~pwrite;
  wire addr_ok = (paddr == `SPC_OFF_FAULT) || (paddr == `SPC_OFF_SWCFG) ||
                 (paddr == `SPC_OFF_SWADDR) || (paddr == `SPC_OFF_STATUS) ||
                 (paddr == `SPC_OFF_ACTIVE);
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~addr_ok;

  reg [15:0] fault_reg;
  reg [7:0]  swcfg_reg;
  reg [7:0]  swaddr_reg;
  reg        addr_rej_reg;

  // (RULE2) fault code held as written, in hex
  // (RULE13) software address outside 1..247 is refused and flagged
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_reg    <= `SPC_FC_NONE;
      swcfg_reg    <= `SPC_CFG_RST;
      swaddr_reg   <= `SPC_ADDR_RST;
      addr_rej_reg <= 1'b0;
    end else if (wr_en) begin
      if (paddr == `SPC_OFF_FAULT)
        fault_reg <= pwdata[15:0];
      if (paddr == `SPC_OFF_SWCFG)
        swcfg_reg <= pwdata[7:0];
      if (paddr == `SPC_OFF_SWADDR) begin
        if (pwdata[7:0] != 8'h00 && pwdata[7:0] <= `SPC_ADDR_MAX_SW &&
            pwdata[31:8] == 24'h000000) begin
          swaddr_reg   <= pwdata[7:0];
          addr_rej_reg <= 1'b0;
        end else begin
          addr_rej_reg <= 1'b1;
        end
      end
    end
  end

  // (RULE20) debounce: a switch word must stay stable for DEB_CYC cycles
  wire [11:0] sw_raw = {protect_switch, framing_switch,
                        tens_address_selector, ones_address_selector};
  reg [11:0] sw_last_reg;
  reg [11:0] sw_stable_reg;
  reg [31:0] deb_cnt_reg;
  // Outputs wait for a first settled word, not the reset value
  reg        sw_valid_reg;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_last_reg   <= 12'h000;
      sw_stable_reg <= 12'h000;
      deb_cnt_reg   <= 32'h00000000;
      sw_valid_reg  <= 1'b0;
    end else begin
      sw_last_reg <= sw_raw;
      if (sw_raw != sw_last_reg)
        deb_cnt_reg <= 32'h00000000;
      else if (deb_cnt_reg < DEB_CYC - 1)
        deb_cnt_reg <= deb_cnt_reg + 32'h00000001;
      else begin
        sw_stable_reg <= sw_last_reg;
        sw_valid_reg  <= 1'b1;
      end
    end
  end

  wire [1:0] prot_pos = sw_stable_reg[11:10];
  wire [1:0] frm_pos  = sw_stable_reg[9:8];
  wire [3:0] tens     = sw_stable_reg[7:4];
  wire [3:0] ones     = sw_stable_reg[3:0];
  // (RULE16) address is tens times ten plus ones
  wire [7:0] rot_addr   = spc_bcd_value(tens, ones);
  wire       digits_ok  = spc_digit_ok(tens) && spc_digit_ok(ones);
  // (RULE17) bad digits or sum above 64 are out of range
  wire       rot_bad    = (rot_addr == 8'h00) ||
                          (rot_addr > {1'b0, `SPC_ADDR_MAX_ROT}) ||
                          !digits_ok;
  // Invalid selection parks the node address and the fixed-mode port address at zero
  wire [7:0] fixed_addr = rot_bad ? 8'h00 : rot_addr;

  // Framing picked by the stable front switch; registered below
  reg [3:0]  baud_next;
  reg        par_en_next;
  reg        par_odd_next;
  reg        data8_next;
  reg        stop2_next;
  reg        rtu_next;
  reg [7:0]  port_addr_next;
  reg        bridge_next;
  always @* begin
    baud_next      = `SPC_BAUD_2400;
    par_en_next    = 1'b1;
    par_odd_next   = 1'b0;
    data8_next     = 1'b0;
    stop2_next     = 1'b0;
    rtu_next       = 1'b0;
    // (RULE11) fixed modes use rotary address
    port_addr_next = fixed_addr;
    // (RULE14) bridge operation by default
    bridge_next    = 1'b1;
    case (frm_pos)
      `SPC_POS_TOP: begin
        // (RULE9) fixed ASCII framing
        baud_next  = `SPC_BAUD_2400;
        data8_next = 1'b0;
        rtu_next   = 1'b0;
      end
      `SPC_POS_MID: begin
        // (RULE10) fixed RTU framing
        baud_next  = `SPC_BAUD_9600;
        data8_next = 1'b1;
        rtu_next   = 1'b1;
      end
      default: begin
        // (RULE12) software framing from config register
        baud_next      = swcfg_reg[`SPC_CFG_BAUD_LSB+3:`SPC_CFG_BAUD_LSB];
        par_en_next    = swcfg_reg[`SPC_CFG_PAR_EN];
        par_odd_next   = swcfg_reg[`SPC_CFG_PAR_ODD];
        data8_next     = swcfg_reg[`SPC_CFG_DATA8];
        stop2_next     = swcfg_reg[`SPC_CFG_STOP2];
        rtu_next       = swcfg_reg[`SPC_CFG_DATA8];
        port_addr_next = swaddr_reg;
        bridge_next    = 1'b0;
      end
    endcase
  end

  // Port settings change only between frames so a byte never splits formats
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_baud_code  <= `SPC_BAUD_2400;
      port_parity_en  <= 1'b1;
      port_parity_odd <= 1'b0;
      port_data8      <= 1'b0;
      port_stop2      <= 1'b0;
      port_rtu        <= 1'b0;
      port_address    <= 8'h00;
      node_address    <= 7'h00;
      bridge_mode     <= 1'b1;
      write_protect   <= 1'b0;
      net_led_invalid <= 1'b0;
    end else if (sw_valid_reg) begin
      // (RULE8) protection only in top position
      write_protect   <= (prot_pos == `SPC_POS_TOP);
      // (RULE18) invalid rotary address lights indicator
      net_led_invalid <= rot_bad;
      // (RULE15) node address from rotary switches
      node_address    <= fixed_addr[6:0];
      // (RULE20) apply only when no frame runs
      if (!frame_busy) begin
        port_baud_code  <= baud_next;
        port_parity_en  <= par_en_next;
        port_parity_odd <= par_odd_next;
        port_data8      <= data8_next;
        port_stop2      <= stop2_next;
        port_rtu        <= rtu_next;
        port_address    <= port_addr_next;
        bridge_mode     <= bridge_next;
      end
    end
  end

  // Blink sequencer; group latched at start so a new code waits for the gap; after code 0000 it waits until no fault is set
  reg [1:0]  st_reg;
  reg [31:0] tmr_reg;
  reg [3:0]  cnt_reg;
  reg [3:0]  grp_reg;
  wire [3:0] grp_now   = spc_group(fault_reg);
  wire       kernel    = (fault_reg == `SPC_FC_KERNEL);
  wire       has_fault = kernel || (grp_now != 4'h0);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg        <= ST_IDLE;
      tmr_reg       <= 32'h00000000;
      cnt_reg       <= 4'h0;
      grp_reg       <= 4'h0;
      run_led_blink <= 1'b0;
    end else begin
      case (st_reg)
        ST_IDLE: begin
          run_led_blink <= 1'b0;
          if (has_fault) begin
            grp_reg       <= grp_now;
            cnt_reg       <= 4'h1;
            tmr_reg       <= 32'h00000000;
            st_reg        <= ST_ON;
            run_led_blink <= 1'b1;
          end
        end
        ST_ON: begin
          // (RULE19) countable on time
          if (tmr_reg >= ON_CYC - 1) begin
            tmr_reg       <= 32'h00000000;
            run_led_blink <= 1'b0;
            st_reg        <= ST_OFF;
          end else begin
            tmr_reg <= tmr_reg + 32'h00000001;
          end
        end
        ST_OFF: begin
          if (tmr_reg >= OFF_CYC - 1) begin
            tmr_reg <= 32'h00000000;
            // (RULE1) kernel mode blinks without gaps
            if (grp_reg == 4'h0) begin
              if (has_fault) begin
                st_reg        <= ST_ON;
                run_led_blink <= 1'b1;
              end else begin
                st_reg <= ST_IDLE;
              end
            end else if (cnt_reg >= grp_reg) begin
              st_reg <= ST_GAP;
            end else begin
              cnt_reg       <= cnt_reg + 4'h1;
              st_reg        <= ST_ON;
              run_led_blink <= 1'b1;
            end
          end else begin
            tmr_reg <= tmr_reg + 32'h00000001;
          end
        end
        ST_GAP: begin
          // (RULE19) longer dark gap between groups
          if (tmr_reg >= GAP_CYC - 1) begin
            tmr_reg <= 32'h00000000;
            st_reg  <= ST_IDLE;
          end else begin
            tmr_reg <= tmr_reg + 32'h00000001;
          end
        end
        default: begin
          st_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Read mux; reserved bits read zero
  always @* begin
    prdata = 32'h00000000;
    if (rd_en) begin
      case (paddr)
        `SPC_OFF_FAULT:  prdata = {16'h0000, fault_reg};
        `SPC_OFF_SWCFG:  prdata = {24'h000000, swcfg_reg};
        `SPC_OFF_SWADDR: prdata = {24'h000000, swaddr_reg};
        `SPC_OFF_STATUS: prdata = {20'h00000, grp_now, 1'b0, addr_rej_reg,
                                   net_led_invalid, write_protect,
                                   frm_pos, bridge_mode, run_led_blink};
        `SPC_OFF_ACTIVE: prdata = {8'h00, node_address, port_address,
                                   port_rtu, port_stop2, port_data8,
                                   port_parity_odd, port_parity_en,
                                   port_baud_code};
        default:         prdata = 32'h00000000;
      endcase
    end
  end

endmodule
`default_nettype wire

/* spc_chk.sv */
// Assertion checker bound to the port configuration block
`timescale 1ns/1ps
`default_nettype none
module spc_chk #(
  parameter integer ON_CYC  = 4,
  parameter integer OFF_CYC = 4,
  parameter integer GAP_CYC = 12,
  parameter integer DEB_CYC = 3
) (
  // Clock, reset and bus
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [11:0] paddr,
  input wire logic        pready,
  input wire logic        pslverr,
  // Panel and engine
  input wire logic [1:0]  protect_switch,
  input wire logic        frame_busy,
  // Port, network and indicators
  input wire logic [3:0]  port_baud_code,
  input wire logic        port_parity_en,
  input wire logic        port_parity_odd,
  input wire logic        port_data8,
  input wire logic        port_stop2,
  input wire logic        port_rtu,
  input wire logic [7:0]  port_address,
  input wire logic [6:0]  node_address,
  input wire logic        bridge_mode,
  input wire logic        write_protect,
  input wire logic        net_led_invalid,
  input wire logic        run_led_blink
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Lit for the simulated on time of four cycles
  sequence s_lit;
    run_led_blink [*4];
  endsequence
  chk_blink_width: assert property ($rose(run_led_blink) |-> s_lit ##1 !run_led_blink)
    else $error("blink on time wrong");
  chk_ready_high: assert property (pready)
    else $error("pready low");
  chk_unmapped_err: assert property (psel && penable && paddr > 12'h010 |-> pslverr)
    else $error("no error on unmapped access");
  chk_ascii_fixed: assert property (bridge_mode && !port_rtu |-> port_baud_code == 4'h5
    && port_parity_en && !port_parity_odd && !port_data8 && !port_stop2)
    else $error("ascii framing wrong");
  chk_rtu_fixed: assert property (bridge_mode && port_rtu |-> port_baud_code == 4'h1
    && port_parity_en && !port_parity_odd && port_data8 && !port_stop2)
    else $error("rtu framing wrong");
  chk_node_limit: assert property (node_address <= 7'h40)
    else $error("node address above limit");
  chk_invalid_zero: assert property (net_led_invalid |-> node_address == 7'h00)
    else $error("invalid address still applied");
  chk_fixed_addr: assert property (!frame_busy ##1 bridge_mode |->
    port_address == {1'b0, node_address})
    else $error("fixed mode address not from rotary");
  chk_busy_hold: assert property (frame_busy ##1 frame_busy |->
    $stable(port_baud_code) && $stable(port_address))
    else $error("settings changed mid frame");
  chk_protect_src: assert property ($rose(write_protect) |-> $past(protect_switch) == 2'h0)
    else $error("protect without top position");
endmodule
bind spc_top spc_chk #(.ON_CYC(ON_CYC), .OFF_CYC(OFF_CYC), .GAP_CYC(GAP_CYC),
  .DEB_CYC(DEB_CYC)) spc_chk_inst (.pclk, .presetn, .psel, .penable, .paddr, .pready,
  .pslverr, .protect_switch, .frame_busy, .port_baud_code, .port_parity_en,
  .port_parity_odd, .port_data8, .port_stop2, .port_rtu, .port_address, .node_address,
  .bridge_mode, .write_protect, .net_led_invalid, .run_led_blink);
`default_nettype wire

/* spc_term_model.sv */
// Terminal model: keeps a frame in progress for a commanded length
`timescale 1ns/1ps
`default_nettype none
module spc_term_model (
  // Clock and reset
  input wire logic       pclk,
  input wire logic       presetn,
  // Frame command
  input wire logic       start,
  input wire logic [7:0] len,
  // Frame activity
  output logic           frame_busy
);
  logic [7:0] cnt_reg;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) cnt_reg <= 8'h00;
    else if (start) cnt_reg <= len;
    else if (cnt_reg != 8'h00) cnt_reg <= cnt_reg - 8'h01;
  end
  assign frame_busy = (cnt_reg != 8'h00);
endmodule
`default_nettype wire

/* spc_top_tb.sv */
// Self-checking bench for the port configuration block
`timescale 1ns/1ps
`default_nettype none
module spc_top_tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err, fs = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rd;
  logic [1:0] protect_switch = 2'h1, framing_switch = 2'h0;
  logic [3:0] tens_address_selector = 4'h0, ones_address_selector = 4'h1;
  logic [7:0] fl = 8'h00;
  wire pready, pslverr, port_parity_en, port_parity_odd, port_data8, port_stop2, port_rtu;
  wire bridge_mode, write_protect, net_led_invalid, run_led_blink, frame_busy;
  wire [31:0] prdata;
  wire [3:0] port_baud_code;
  wire [7:0] port_address;
  wire [6:0] node_address;
  integer failures = 0, compares = 0, cycles = 0, n, i;
  logic [15:0] codes [10] = '{16'h080B, 16'h082E, 16'h0769, 16'h0730, 16'h0604,
                              16'h0631, 16'h052D, 16'h0402, 16'h0301, 16'h8003};
  logic [3:0] grps [10] = '{4'h2, 4'h2, 4'h3, 4'h3, 4'h4, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8};
  spc_top #(.ON_CYC(4), .OFF_CYC(4), .GAP_CYC(12), .DEB_CYC(3)) spc_top_inst (.pclk,
    .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .prdata,
    .protect_switch, .framing_switch, .tens_address_selector, .ones_address_selector,
    .frame_busy, .port_baud_code, .port_parity_en, .port_parity_odd, .port_data8,
    .port_stop2, .port_rtu, .port_address, .node_address, .bridge_mode, .write_protect,
    .net_led_invalid, .run_led_blink);
  spc_term_model spc_term_model_inst (.pclk, .presetn, .start(fs), .len(fl), .frame_busy);
  always #2 pclk = ~pclk;
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures = failures + 1;
      stop_test;
    end
  end
  task stop_test;
    if (failures == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares = compares + 1;
    if (seen !== exp) begin
      failures = failures + 1;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Debounce window plus sync edges, with margin
  task sw(input logic [1:0] p, input logic [1:0] f, input logic [3:0] t, input logic [3:0] o);
    @(posedge pclk);
    protect_switch <= p; framing_switch <= f;
    tens_address_selector <= t; ones_address_selector <= o;
    repeat (10) @(posedge pclk);
  endtask
  // Counts rises until a dark run longer than the off time
  task count_blinks(output integer c);
    integer lo, t;
    logic prev;
    c = 0; lo = 0; t = 0; prev = run_led_blink;
    while (lo < 8 && t < 200) begin
      @(posedge pclk);
      t = t + 1;
      if (run_led_blink === 1'b1 && prev !== 1'b1) c = c + 1;
      if (run_led_blink === 1'b1) lo = 0;
      else if (c > 0) lo = lo + 1;
      prev = run_led_blink;
    end
  endtask
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    chk("wprot_rst", write_protect, 0);
    chk("led_rst", net_led_invalid, 0);
    apb(0, 12'h000, 0); chk("fault_rst", rd, 32'h0000FFFF);
    chk("fault_err", err, 0);
    apb(0, 12'h008, 0); chk("swaddr_rst", rd, 32'h1);
    apb(0, 12'h020, 0); chk("unmapped_err", err, 1);
    chk("unmapped_rd", rd, 32'h0);
    sw(2'h0, 2'h0, 4'h1, 4'h1);
    chk("ascii_baud", port_baud_code, 4'h5);
    chk("ascii_fmt", {port_rtu, port_stop2, port_data8, port_parity_odd, port_parity_en}, 5'h01);
    chk("addr_11", port_address, 8'd11);
    chk("node_11", node_address, 7'd11);
    chk("bridge", bridge_mode, 1);
    chk("wprot_top", write_protect, 1);
    sw(2'h1, 2'h1, 4'h6, 4'h4);
    chk("rtu_baud", port_baud_code, 4'h1);
    chk("rtu_data8", port_data8, 1);
    chk("rtu_fmt", {port_rtu, port_stop2, port_data8, port_parity_odd, port_parity_en}, 5'h15);
    apb(0, 12'h010, 0);
    chk("active", rd, {8'h00, 7'd64, 8'd64, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 4'h1});
    chk("addr_64", port_address, 8'd64);
    chk("led_64", net_led_invalid, 0);
    chk("wprot_mid", write_protect, 0);
    sw(2'h2, 2'h1, 4'h6, 4'h5); chk("led_65", net_led_invalid, 1);
    chk("wprot_bot", write_protect, 0);
    sw(2'h2, 2'h1, 4'h0, 4'h0); chk("led_0", net_led_invalid, 1);
    sw(2'h2, 2'h2, 4'h0, 4'h1);
    apb(1, 12'h004, 32'hFC); apb(1, 12'h008, 32'd247); repeat (4) @(posedge pclk);
    chk("sw_cfg", {port_stop2, port_data8, port_parity_odd, port_parity_en,
        port_baud_code}, 8'hFC);
    chk("sw_addr", port_address, 8'd247);
    chk("sw_bridge", bridge_mode, 0);
    apb(1, 12'h008, 32'd248); apb(1, 12'h008, 32'd0); apb(0, 12'h00C, 0);
    chk("rej_flag", rd[6], 1); chk("rej_addr", port_address, 8'd247);
    apb(1, 12'h008, 32'd1); apb(0, 12'h00C, 0);
    chk("ok_flag", rd[6], 0); chk("addr_1", port_address, 8'd1);
    @(posedge pclk); fs <= 1'b1; fl <= 8'd60;
    @(posedge pclk); fs <= 1'b0;
    sw(2'h2, 2'h0, 4'h0, 4'h1); chk("busy_hold", port_baud_code, 4'hC);
    repeat (60) @(posedge pclk);
    chk("ascii_after", port_baud_code, 4'h5);
    apb(1, 12'h004, 32'h00); repeat (4) @(posedge pclk);
    chk("ascii_locked", port_baud_code, 4'h5);
    for (i = 0; i < 10; i = i + 1) begin
      apb(1, 12'h000, {16'h0, codes[i]}); apb(0, 12'h00C, 0);
      chk("group", rd[11:8], grps[i]);
      count_blinks(n); count_blinks(n);
      chk("blinks", n, grps[i]);
    end
    apb(1, 12'h000, 32'h0); count_blinks(n); count_blinks(n);
    chk("kernel", n >= 20, 1);
    apb(1, 12'h000, 32'hFFFF); count_blinks(n); count_blinks(n);
    chk("no_fault", n, 0);
    stop_test;
  end
endmodule
`default_nettype wire
